// [pssls_pkg.sv]
// package for the parameter-set switching and low-speed sleep block
// assumes one 100 MHz control clock and a plain word-indexed register port
package pssls_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TENTH_SEC_NS = 100_000_000;
   localparam int TICK_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;

   // widths and counts
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int SLOTS = 15;
   localparam int SETS = 3;
   localparam int SRC_W = 6;
   localparam int PID_W = 6;
   localparam int CNT_W = 4;

   // register indices
   localparam logic [7:0] REG_SRC = 8'h00;
   localparam logic [7:0] REG_SEL = 8'h01;
   localparam logic [7:0] REG_TIMEOUT = 8'h02;
   localparam logic [7:0] REG_OFFSET = 8'h03;
   localparam logic [7:0] REG_ADV = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h05;
   localparam logic [7:0] REG_LIST_BASE = 8'h10;
   localparam logic [7:0] REG_SET_BASE = 8'h40;
   localparam logic [7:0] SET_STRIDE = 8'h10;

   // field positions
   localparam int SRC2_LSB = 8;
   localparam int SEL_DEL_BIT = 15;

   // selection source codes
   localparam logic [5:0] SRC_NONE = 6'h00;
   localparam logic [5:0] SRC_FREQ_HIGH = 6'h01;
   localparam logic [5:0] SRC_FREQ2 = 6'h02;
   localparam logic [5:0] SRC_DI_BASE = 6'h03;
   localparam logic [5:0] SRC_EXT_BASE = 6'h09;
   localparam logic [5:0] SRC_CMD_BASE = 6'h10;
   localparam logic [3:0] CMD_IO_ONLY_LAST = 4'hA;

   // reset values and limits (frequencies in 0.1 Hz, time in 0.1 s)
   localparam logic [15:0] TIMEOUT_RST = 16'h0000;
   localparam logic [15:0] TIMEOUT_MAX = 16'h270F;
   localparam logic [15:0] OFFSET_RST = 16'h000A;
   localparam logic [15:0] OFFSET_MIN = 16'h000A;

   typedef enum logic [1:0] {
      PSSLS_MONITOR = 2'b00,
      PSSLS_TIMING = 2'b01,
      PSSLS_ASLEEP = 2'b10
   } pssls_state_type;

   // frequencies seen by the sleep logic
   typedef struct packed {
      logic [15:0] preramp_ref;
      logic [15:0] output_freq;
      logic [15:0] minimum_speed_setting;
      logic [15:0] max_freq;
   } pssls_freq_type;

   // regulator and command status
   typedef struct packed {
      logic reg_configured;
      logic reg_manual;
      logic reg_channel_sel;
      logic run_cmd;
      logic ctrl_pressure;
      logic sleep_detect_on;
   } pssls_ctl_type;

   // selection inputs
   typedef struct packed {
      logic motor_freq_high_reached;
      logic second_freq_thd_reached;
      logic [5:0] physical_input;
      logic [5:0] ext_input;
      logic [15:0] ctrl_word;
      logic io_profile;
   } pssls_src_type;

   typedef logic [SLOTS-1:0][DATA_W-1:0] pssls_vals_type;
   typedef logic [SLOTS-1:0][PID_W-1:0] pssls_ids_type;

endpackage

// [pssls_top.sv]
// parameter-set switching and low-speed timeout sleep for a motor drive
// assumes synchronous inputs on one clock and a one-cycle-latency register port
`timescale 1ns/1ps
module pssls_top #(
   parameter int P_TICK_CYCLES = pssls_pkg::TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [pssls_pkg::ADDR_W-1:0] i_addr,
   input wire logic [pssls_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [pssls_pkg::DATA_W-1:0] o_rdata,
   input wire pssls_pkg::pssls_src_type i_src,
   input wire pssls_pkg::pssls_freq_type i_freq,
   input wire pssls_pkg::pssls_ctl_type i_ctl,
   output logic [1:0] o_active_set,
   output pssls_pkg::pssls_vals_type o_values,
   output pssls_pkg::pssls_ids_type o_param_ids,
   output logic [pssls_pkg::CNT_W-1:0] o_sel_count,
   output logic o_stop_req,
   output logic o_adv_sleep_en
);
   import pssls_pkg::*;

   logic [SRC_W-1:0] src1_reg;
   logic [SRC_W-1:0] src2_reg;
   logic [PID_W-1:0] id_reg [SLOTS];
   logic [CNT_W-1:0] cnt_reg;
   logic [DATA_W-1:0] val_reg [SETS][SLOTS];
   logic [DATA_W-1:0] timeout_reg;
   logic [DATA_W-1:0] offset_reg;
   logic adv_reg;
   pssls_state_type state_reg;
   pssls_state_type state_next;
   logic [31:0] div_reg;
   logic [DATA_W-1:0] tenth_reg;
   logic [1:0] set_next;
   logic sel1;
   logic sel2;
   logic [16:0] thd;
   logic below;
   logic ref_above;
   logic speed_mode;
   logic tick;
   logic wr_sel;
   logic [PID_W-1:0] wr_id;
   logic found;
   logic [CNT_W-1:0] found_idx;
   logic set_hit;
   logic [1:0] set_idx;
   logic [CNT_W-1:0] slot_idx;

   // level of one selection source; unassigned reads as 0
   function automatic logic src_level(input logic [SRC_W-1:0] code, input pssls_src_type s);
      logic [SRC_W-1:0] off;
      off = '0;
      if (code == SRC_FREQ_HIGH) begin
         return s.motor_freq_high_reached;
      end else if (code == SRC_FREQ2) begin
         return s.second_freq_thd_reached;
      end else if (code >= SRC_DI_BASE && code < SRC_EXT_BASE) begin
         off = code - SRC_DI_BASE;
         return s.physical_input[off[2:0]];
      end else if (code >= SRC_EXT_BASE && code < SRC_EXT_BASE + 6'h06) begin
         off = code - SRC_EXT_BASE;
         return s.ext_input[off[2:0]];
      // upper end written as the last code, so the 6-bit sum cannot wrap to zero
      end else if (code >= SRC_CMD_BASE && code <= SRC_CMD_BASE + 6'h0F) begin
         off = code - SRC_CMD_BASE;
         // low bits only count in the io profile
         if (off[3:0] <= CMD_IO_ONLY_LAST && !s.io_profile) begin
            return 1'b0;
         end
         return s.ctrl_word[off[3:0]];
      end
      return 1'b0;
   endfunction

   // only defined codes are accepted, otherwise the source is left unassigned
   // codes past the last control-word bit would otherwise store and read back as live
   function automatic logic [SRC_W-1:0] src_legal(input logic [SRC_W-1:0] code);
      if (code <= SRC_EXT_BASE + 6'h05) begin
         return code;
      end
      if (code >= SRC_CMD_BASE && code <= SRC_CMD_BASE + 6'h0F) begin
         return code;
      end
      return SRC_NONE;
   endfunction

   // set decode from the two sources
   always_comb begin
      sel1 = (src1_reg != SRC_NONE) && src_level(src1_reg, i_src);
      sel2 = (src1_reg != SRC_NONE) && src_level(src2_reg, i_src);
      if (sel2) begin
         set_next = 2'h2;
      end else if (sel1) begin
         set_next = 2'h1;
      end else begin
         set_next = 2'h0;
      end
   end

   // register address decode
   always_comb begin
      wr_sel = i_wr && (i_addr == REG_SEL);
      wr_id = i_wdata[PID_W-1:0];
      set_hit = (i_addr >= REG_SET_BASE) && (i_addr < REG_SET_BASE + 8'h30)
         && (i_addr[3:0] < 4'hF);
      set_idx = 2'(((i_addr - REG_SET_BASE) >> 4));
      slot_idx = i_addr[3:0];
      found = 1'b0;
      found_idx = '0;
      for (int i = 0; i < SLOTS; i++) begin
         if (!found && (4'(i) < cnt_reg) && (id_reg[i] == wr_id)) begin
            found = 1'b1;
            found_idx = 4'(i);
         end
      end
   end

   // source assignment; clearing source one also drops the second source's effect
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         src1_reg <= SRC_NONE;
         src2_reg <= SRC_NONE;
      end else if (i_wr && i_addr == REG_SRC) begin
         src1_reg <= src_legal(i_wdata[SRC_W-1:0]);
         src2_reg <= src_legal(i_wdata[SRC2_LSB+SRC_W-1:SRC2_LSB]);
      end
   end

   // ordered selection list; a full list refuses further additions
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= '0;
         for (int i = 0; i < SLOTS; i++) begin
            id_reg[i] <= '0;
         end
      end else if (wr_sel && src1_reg != SRC_NONE) begin
         if (i_wdata[SEL_DEL_BIT]) begin
            if (found) begin
               // close the gap so the remaining order is kept
               for (int i = 0; i < SLOTS - 1; i++) begin
                  if (4'(i) >= found_idx) begin
                     id_reg[i] <= id_reg[i+1];
                  end
               end
               cnt_reg <= cnt_reg - 4'h1;
            end
         end else if (!found && cnt_reg < 4'(SLOTS)) begin
            id_reg[cnt_reg] <= wr_id;
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end

   // value sets, one slot per selected parameter position
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int s = 0; s < SETS; s++) begin
            for (int i = 0; i < SLOTS; i++) begin
               val_reg[s][i] <= '0;
            end
         end
      end else if (i_wr && set_hit) begin
         val_reg[set_idx][slot_idx] <= i_wdata;
      end
   end

   // active set and its values follow the sources at any time, running or not
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_active_set <= 2'h0;
         o_values <= '0;
         o_param_ids <= '0;
         o_sel_count <= '0;
      end else begin
         o_active_set <= set_next;
         for (int i = 0; i < SLOTS; i++) begin
            o_values[i] <= val_reg[set_next][i];
            o_param_ids[i] <= id_reg[i];
         end
         o_sel_count <= cnt_reg;
      end
   end

   // sleep settings with range limits applied at write
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         timeout_reg <= TIMEOUT_RST;
         offset_reg <= OFFSET_RST;
         adv_reg <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == REG_TIMEOUT) begin
            timeout_reg <= (i_wdata > TIMEOUT_MAX) ? TIMEOUT_MAX : i_wdata;
         end
         if (i_addr == REG_OFFSET) begin
            if (i_wdata < OFFSET_MIN) begin
               offset_reg <= OFFSET_MIN;
            end else if (i_wdata > i_freq.max_freq) begin
               offset_reg <= i_freq.max_freq;
            end else begin
               offset_reg <= i_wdata;
            end
         end
         if (i_addr == REG_ADV) begin
            adv_reg <= i_wdata[0];
         end
      end
   end

   // advanced sleep gate
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_adv_sleep_en <= 1'b0;
      end else begin
         o_adv_sleep_en <= adv_reg && i_ctl.ctrl_pressure && i_ctl.sleep_detect_on;
      end
   end

   // threshold compare every cycle; 17 bits so the sum cannot wrap
   always_comb begin
      thd = {1'b0, i_freq.minimum_speed_setting} + {1'b0, offset_reg};
      below = ({1'b0, i_freq.preramp_ref} < thd) && ({1'b0, i_freq.output_freq} < thd);
      ref_above = {1'b0, i_freq.preramp_ref} > thd;
      speed_mode = !i_ctl.reg_configured || i_ctl.reg_manual || !i_ctl.reg_channel_sel;
      tick = (div_reg == 32'(P_TICK_CYCLES - 1));
   end

   // sleep sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PSSLS_MONITOR: begin
            if (speed_mode && timeout_reg != '0 && below && i_ctl.run_cmd) begin
               state_next = PSSLS_TIMING;
            end
         end
         PSSLS_TIMING: begin
            if (!below || !speed_mode || timeout_reg == '0 || !i_ctl.run_cmd) begin
               state_next = PSSLS_MONITOR;
            end else if (tick && tenth_reg + 16'h0001 >= timeout_reg) begin
               state_next = PSSLS_ASLEEP;
            end
         end
         PSSLS_ASLEEP: begin
            if (!i_ctl.run_cmd || !speed_mode || timeout_reg == '0) begin
               state_next = PSSLS_MONITOR;
            end else if (ref_above) begin
               state_next = PSSLS_MONITOR;
            end
         end
         default: begin
            state_next = PSSLS_MONITOR;
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= PSSLS_MONITOR;
      end else begin
         state_reg <= state_next;
      end
   end

   // tenth-second divider, restarted whenever timing is not running
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_reg <= '0;
         tenth_reg <= '0;
      end else if (state_reg != PSSLS_TIMING || state_next != PSSLS_TIMING) begin
         div_reg <= '0;
         tenth_reg <= '0;
      end else if (tick) begin
         div_reg <= '0;
         tenth_reg <= tenth_reg + 16'h0001;
      end else begin
         div_reg <= div_reg + 32'h1;
      end
   end

   // stop request; the ramp generator brings the motor down on its active decel
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_stop_req <= 1'b0;
      end else begin
         o_stop_req <= (state_next == PSSLS_ASLEEP);
      end
   end

   // read port, data valid in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= '0;
         if (i_addr == REG_SRC) begin
            o_rdata <= {2'h0, src2_reg, 2'h0, src1_reg};
         end else if (i_addr == REG_SEL) begin
            o_rdata <= {12'h000, cnt_reg};
         end else if (i_addr == REG_TIMEOUT) begin
            o_rdata <= timeout_reg;
         end else if (i_addr == REG_OFFSET) begin
            o_rdata <= offset_reg;
         end else if (i_addr == REG_ADV) begin
            o_rdata <= {15'h0000, adv_reg};
         end else if (i_addr == REG_STATUS) begin
            o_rdata <= {12'h000, state_reg, o_active_set};
         end else if (i_addr >= REG_LIST_BASE && i_addr < REG_LIST_BASE + 8'h0F) begin
            o_rdata <= {10'h000, id_reg[i_addr[3:0]]};
         end else if (set_hit) begin
            o_rdata <= val_reg[set_idx][slot_idx];
         end
      end else begin
         o_rdata <= '0;
      end
   end

endmodule

// [pssls_chk.sv]
// assertions for the set switching and low-speed sleep block
// sees only the top ports; bound from the testbench top file
`timescale 1ns/1ps
module pssls_chk
   import pssls_pkg::*;
#(
   parameter int P_TICK_CYCLES = TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_wr,
   input wire pssls_pkg::pssls_freq_type i_freq,
   input wire pssls_pkg::pssls_ctl_type i_ctl,
   input wire logic [1:0] o_active_set,
   input wire logic o_stop_req,
   input wire logic o_adv_sleep_en
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   logic spd;
   logic [31:0] run_cnt;
   // speed mode: regulator absent, manual, or not on its channel
   assign spd = !i_ctl.reg_configured || i_ctl.reg_manual || !i_ctl.reg_channel_sel;
   // run length in speed mode; a stop is only legal after a full dwell
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         run_cnt <= 32'h0;
      end else if (spd && i_ctl.run_cmd) begin
         run_cnt <= run_cnt + 32'h1;  // 32 bits wraps before a maximum-timeout run reaches its stop
      end else begin
         run_cnt <= 32'h0;
      end
   end
   chk_stop_dwell: assert property (
      $rose(o_stop_req) |-> run_cnt >= P_TICK_CYCLES) else $error("stop before a full dwell");
   chk_stop_below: assert property (
      $rose(o_stop_req) |-> $past({1'b0, i_freq.output_freq}) <
         $past({1'b0, i_freq.minimum_speed_setting} + {1'b0, i_freq.max_freq})) else $error("stop while fast");
   chk_stop_cause: assert property (
      o_stop_req |-> $past(spd && i_ctl.run_cmd)) else $error("stop outside speed mode");
   chk_mode_exit: assert property (
      o_stop_req && !spd |=> !o_stop_req) else $error("stop held after mode change");
   chk_run_exit: assert property (
      !i_ctl.run_cmd |=> !o_stop_req) else $error("stop held without run");
   chk_wake_ref: assert property (
      o_stop_req && i_ctl.run_cmd && spd && !i_wr && !$past(i_wr) &&
      ({1'b0, i_freq.preramp_ref} <= {1'b0, i_freq.minimum_speed_setting} + 17'h0000A)
      |=> o_stop_req) else $error("woke below threshold");
   chk_adv_gate: assert property (
      !(i_ctl.ctrl_pressure && i_ctl.sleep_detect_on) |=> !o_adv_sleep_en) else $error("adv sleep ungated");
   chk_set_range: assert property (
      o_active_set != 2'h3) else $error("no fourth set");
   cover property ($rose(o_stop_req));
   cover property ($fell(o_stop_req));
   cover property (o_active_set == 2'h2);
endmodule

// [pssls_tb_top.sv]
// self-checking bench for the set switching and low-speed sleep block
// drives every port at the rising edge; sleep tick shortened to 4 cycles
`timescale 1ns/1ps
module pssls_tb_top;
   import pssls_pkg::*;
   localparam int TICK = 4;
   logic i_clk;
   logic i_rstn;
   logic i_wr;
   logic i_rd;
   logic [7:0] i_addr;
   logic [15:0] i_wdata;
   logic [15:0] o_rdata;
   pssls_src_type i_src;
   pssls_freq_type i_freq;
   pssls_ctl_type i_ctl;
   logic [1:0] o_active_set;
   pssls_vals_type o_values;
   pssls_ids_type o_param_ids;
   logic [3:0] o_sel_count;
   logic o_stop_req;
   logic o_adv_sleep_en;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;

   pssls_top #(.P_TICK_CYCLES(TICK)) uut (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_src(i_src), .i_freq(i_freq), .i_ctl(i_ctl), .o_active_set(o_active_set),
      .o_values(o_values), .o_param_ids(o_param_ids), .o_sel_count(o_sel_count), .o_stop_req(o_stop_req),
      .o_adv_sleep_en(o_adv_sleep_en)
   );

   task automatic results();
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // register port: one-cycle strobes, read data only in the following cycle
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      cmp(name, exp, o_rdata);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // level inputs; two edges cover sampling plus the output register
   task automatic drv(input pssls_src_type s);
      @(posedge i_clk);
      i_src <= s;
      idle(2);
   endtask
   task automatic ctl(input pssls_ctl_type c);
      @(posedge i_clk);
      i_ctl <= c;
   endtask
   task automatic frq(input logic [15:0] pre, input logic [15:0] out);
      @(posedge i_clk);
      i_freq <= {pre, out, 16'h0064, 16'h01F4};
   endtask
   task automatic hold(input int n, input logic v, input string name);
      idle(n);
      cmp(name, {15'h0000, v}, {15'h0000, o_stop_req});
   endtask
   // bounded wait for the stop output to reach a level
   task automatic reach(input int hi, input logic v, input string name);
      int k;
      k = 0;
      while (o_stop_req !== v && k < hi) begin
         idle(1);
         k++;
      end
      cmp(name, {15'h0000, v}, {15'h0000, o_stop_req});
   endtask

   task automatic t_regs();
      rd(REG_TIMEOUT, TIMEOUT_RST, "timeout reset");
      rd(REG_OFFSET, OFFSET_RST, "offset reset");
      rd(REG_ADV, 16'h0000, "adv reset");
      wr(8'h3F, 16'hFFFF);
      rd(8'h3F, 16'h0000, "unmapped place");
      wr(REG_SRC, 16'h0F20);
      rd(REG_SRC, 16'h0000, "undefined codes");
      drv({2'b11, 29'h00000000});
      cmp("unassigned source", 16'h0000, {14'h0000, o_active_set});
      wr(REG_TIMEOUT, 16'hFFFF);
      rd(REG_TIMEOUT, TIMEOUT_MAX, "timeout clamp");
      wr(REG_TIMEOUT, 16'h0000);
      wr(REG_OFFSET, 16'hFFFF);
      rd(REG_OFFSET, 16'h01F4, "offset ceiling");
      wr(REG_OFFSET, 16'h0000);
      rd(REG_OFFSET, OFFSET_MIN, "offset floor");
   endtask
   // list is gated by source one, kept in order and capped at fifteen
   task automatic t_select();
      wr(REG_SEL, 16'h0005);
      rd(REG_SEL, 16'h0000, "count unassigned");
      wr(REG_SRC, {10'h000, SRC_FREQ_HIGH});
      wr(REG_SEL, 16'h0005);
      wr(REG_SEL, 16'h0007);
      wr(REG_SEL, 16'h0009);
      wr(REG_SEL, 16'h0005);
      rd(8'h11, 16'h0007, "second id");
      cmp("id slot 2", 16'h0009, {10'h000, o_param_ids[2]});
      wr(REG_SEL, 16'h8007);
      rd(REG_SEL, 16'h0002, "count after delete");
      for (int k = 20; k < 40; k++) wr(REG_SEL, 16'(k));
      cmp("count full", 16'h000F, {12'h000, o_sel_count});
   endtask
   // all flag pairs while the motor runs
   task automatic t_switch();
      logic [1:0] exp;
      for (int s = 0; s < 3; s++) wr(8'(REG_SET_BASE + SET_STRIDE * s), 16'hA000 | 16'(s));
      ctl(6'b000100);
      wr(REG_SRC, {2'b00, SRC_FREQ2, 2'b00, SRC_FREQ_HIGH});
      for (int m = 0; m < 4; m++) begin
         exp = (m > 1) ? 2'h2 : 2'(m);
         drv({m[0], m[1], 29'h00000000});
         cmp("active set", {14'h0000, exp}, {14'h0000, o_active_set});
         cmp("slot 0 value", 16'hA000 | {14'h0000, exp}, o_values[0]);
      end
      wr(REG_SRC, {2'b00, SRC_FREQ2, 2'b00, SRC_NONE});
      drv({2'b01, 29'h00000000});
      cmp("second source alone", 16'h0000, {14'h0000, o_active_set});
   endtask
   // every defined code as source two, without and with the io profile
   task automatic t_sources();
      pssls_src_type s;
      logic [1:0] exp;
      for (int io = 0; io < 2; io++) begin
         for (int c = 1; c < 32; c++) begin
            if (c == 15) continue;
            wr(REG_SRC, 16'((c << 8) | 1));
            s = '0;
            s.io_profile = io[0];
            if (c == 1) s.motor_freq_high_reached = 1'b1;
            else if (c == 2) s.second_freq_thd_reached = 1'b1;
            else if (c < 9) s.physical_input[c - 3] = 1'b1;
            else if (c < 15) s.ext_input[c - 9] = 1'b1;
            else s.ctrl_word[c - 16] = 1'b1;
            exp = (c > 15 && c < 27 && io == 0) ? 2'h0 : 2'h2;
            drv(s);
            cmp("source code", {14'h0000, exp}, {14'h0000, o_active_set});
         end
      end
   endtask
   // threshold 110 from minimum 100 plus offset 10; timeout 2 ticks
   task automatic t_sleep();
      drv('0);
      wr(REG_TIMEOUT, 16'h0002);
      frq(16'h0032, 16'h0032);
      hold(7, 1'b0, "before timeout");
      reach(4, 1'b1, "timeout stop");
      rd(REG_STATUS, 16'h0008, "status asleep");
      frq(16'h006E, 16'h0032);
      hold(6, 1'b1, "at threshold");
      frq(16'h006F, 16'h0032);
      reach(3, 1'b0, "wake");
      frq(16'h0032, 16'h0032);
      idle(5);
      frq(16'h0032, 16'h00C8);
      frq(16'h0032, 16'h0032);
      hold(8, 1'b0, "restarted count");
      reach(4, 1'b1, "stop after restart");
      ctl(6'b000000);
      reach(3, 1'b0, "run removed");
      ctl(6'b101100);
      hold(20, 1'b0, "regulator active");
      ctl(6'b111100);
      reach(12, 1'b1, "manual mode");
      ctl(6'b101100);
      reach(3, 1'b0, "speed mode lost");
      ctl(6'b100100);
      reach(12, 1'b1, "channel off");
      wr(REG_TIMEOUT, 16'h0000);
      reach(3, 1'b0, "timeout cleared");
      hold(20, 1'b0, "zero timeout");
   endtask
   // mid-run reset: outputs and settings go back to their reset values
   task automatic t_reset();
      @(posedge i_clk);
      i_rstn <= 1'b0;
      idle(2);
      cmp("count in reset", 16'h0000, {12'h000, o_sel_count});
      cmp("stop in reset", 16'h0000, {15'h0000, o_stop_req});
      @(posedge i_clk);
      i_rstn <= 1'b1;
      rd(REG_SRC, 16'h0000, "source after reset");
      rd(REG_TIMEOUT, TIMEOUT_RST, "timeout after reset");
   endtask
   task automatic t_adv();
      ctl(6'b000111);
      idle(2);
      cmp("adv not enabled", 16'h0000, {15'h0000, o_adv_sleep_en});
      wr(REG_ADV, 16'h0001);
      idle(2);
      cmp("adv enabled", 16'h0001, {15'h0000, o_adv_sleep_en});
      ctl(6'b000110);
      idle(2);
      cmp("adv detect off", 16'h0000, {15'h0000, o_adv_sleep_en});
      rd(REG_ADV, 16'h0001, "adv readback");
   endtask

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // hang guard: the whole run needs well under two thousand cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      i_rstn = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 16'h0000;
      i_src = '0;
      i_ctl = '0;
      i_freq = {16'h0032, 16'h0032, 16'h0064, 16'h01F4};
      repeat (12) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_regs();
      t_select();
      t_switch();
      t_sources();
      t_sleep();
      t_reset();
      t_adv();
      results();
   end
endmodule

bind pssls_top pssls_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_chk (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_wr(i_wr), .i_freq(i_freq), .i_ctl(i_ctl),
   .o_active_set(o_active_set), .o_stop_req(o_stop_req), .o_adv_sleep_en(o_adv_sleep_en)
);
